// *** core/bci_consts.svh ***
`ifndef BCI_CONSTS_SVH
`define BCI_CONSTS_SVH

// ==========================================================
// function codes
`define BCI_FC_W          8
`define BCI_FC_SECTION    8'h02
`define BCI_FC_SECT_CLR   8'h03
`define BCI_FC_LATCH      8'h0b
`define BCI_FC_RISE       8'h0d
`define BCI_FC_FALL       8'h0e
`define BCI_FC_OUT        8'h40
`define BCI_FC_OUT_NOT    8'h41

// ==========================================================
// data areas and reset values
`define BCI_AREA_W        2
`define BCI_AREA_INT      2'h0
`define BCI_AREA_RET      2'h1
`define BCI_AREA_AUX      2'h2
`define BCI_AREA_BAD      2'h3
`define BCI_BIT_RST       1'h0
`define BCI_PC_STEP       1

`endif

// *** core/bci_pkg.sv ***
package bci_pkg;
`include "bci_consts.svh"

  // instruction function codes
  typedef enum logic [`BCI_FC_W-1:0] {
    BCI_F_SECTION  = `BCI_FC_SECTION,
    BCI_F_SECT_CLR = `BCI_FC_SECT_CLR,
    BCI_F_LATCH    = `BCI_FC_LATCH,
    BCI_F_RISE     = `BCI_FC_RISE,
    BCI_F_FALL     = `BCI_FC_FALL,
    BCI_F_OUT      = `BCI_FC_OUT,
    BCI_F_OUT_NOT  = `BCI_FC_OUT_NOT
  } bci_func_type;

  // operand data areas
  typedef enum logic [`BCI_AREA_W-1:0] {
    BCI_A_INT = `BCI_AREA_INT,
    BCI_A_RET = `BCI_AREA_RET,
    BCI_A_AUX = `BCI_AREA_AUX,
    BCI_A_BAD = `BCI_AREA_BAD
  } bci_area_type;

  // scan phase
  typedef enum logic [0:0] {
    BCI_S_IDLE = 1'b0,
    BCI_S_RUN  = 1'b1
  } bci_state_type;

endpackage : bci_pkg

// *** core/bci_unit.sv ***
// ==========================================================
// Contract
// - rising pulse: bit on one scan
// - falling pulse: bit on one scan, condition on before, off now
// - next execution turns pulse bit off
// - latch set line on forces bit on unless reset line is also on
// - latch reset line forces off, holds when both lines are off
// - latch holds value inside closed section
// - earlier line is set, later is reset
// - self-holding output drops in closed section
// - output stores condition, readable same scan
// - operands in internal, retentive, auxiliary areas
// - work bits never reach output pins
// - codes 13 rise, 14 fall, 11 latch
// - single bit operand ends each line
// - closed section runs with conditions off
// - instructions executed in program order
`timescale 1ns/10ps
`include "bci_consts.svh"

module bci_unit #(
  parameter int AREA_BITS = 256,
  parameter int PROG_LEN  = 256,
  parameter int OUT_BITS  = 16
) (
  // clock and reset
  input  wire logic                          I_CLK,
  input  wire logic                          I_RST,
  // scan framing
  input  wire logic                          I_SCAN_START,
  input  wire logic                          I_SCAN_END,
  // instruction stream
  input  wire logic                          I_EXEC,
  input  wire bci_pkg::bci_func_type         I_FUNC,
  input  wire bci_pkg::bci_area_type         I_AREA,
  input  wire logic [$clog2(AREA_BITS)-1:0]  I_ADDR,
  input  wire logic                          I_COND,
  input  wire logic                          I_COND_RESET,
  // condition read port
  input  wire bci_pkg::bci_area_type         I_RD_AREA,
  input  wire logic [$clog2(AREA_BITS)-1:0]  I_RD_ADDR,
  output logic                               O_RD_BIT,
  // status and pins
  output logic [OUT_BITS-1:0]                O_EXT_OUT,
  output logic [$clog2(PROG_LEN)-1:0]        O_PC,
  output logic                               O_SECTION_CLOSED,
  output logic                               O_RUN,
  output logic                               O_SCAN_DONE,
  output logic                               O_ERR
);
  import bci_pkg::*;

  localparam int AW = $clog2(AREA_BITS);
  localparam int PW = $clog2(PROG_LEN);

  // ==========================================================
  // state
  bci_state_type              state_reg, state_next;
  logic [AREA_BITS-1:0]       int_reg, int_next;
  logic [AREA_BITS-1:0]       ret_reg, ret_next;
  logic [AREA_BITS-1:0]       aux_reg, aux_next;
  logic [PROG_LEN-1:0]        hist_reg, hist_next;
  logic [PW-1:0]              pc_reg, pc_next;
  logic                       closed_reg, closed_next;
  logic                       rd_reg, rd_next;
  logic [OUT_BITS-1:0]        ext_reg, ext_next;
  logic                       done_reg, done_next;
  logic                       err_reg, err_next;

  // working values of the current instruction
  logic                       cond_eff;
  logic                       rst_eff;
  logic                       cur_bit;
  logic                       new_bit;
  logic                       wr_en;
  logic                       valid_area;
  logic                       prev_cond;
  logic                       end_take;
  logic                       step_take;
  logic                       bit_instr;

  // ==========================================================
  // operand bit currently stored
  always_comb begin
    case (I_AREA)
      BCI_A_INT: cur_bit = int_reg[I_ADDR];
      BCI_A_RET: cur_bit = ret_reg[I_ADDR];
      BCI_A_AUX: cur_bit = aux_reg[I_ADDR];
      default:   cur_bit = `BCI_BIT_RST;
    endcase
  end

  // ==========================================================
  // instruction evaluation
  always_comb begin
    valid_area = (I_AREA != BCI_A_BAD);
    prev_cond  = hist_reg[pc_reg];
    cond_eff   = I_COND & ~closed_reg;
    rst_eff    = I_COND_RESET & ~closed_reg;
    new_bit    = cur_bit;
    wr_en      = 1'b0;
    case (I_FUNC)
      BCI_F_OUT: begin
        new_bit = cond_eff;
        wr_en   = 1'b1;
      end
      BCI_F_OUT_NOT: begin
        new_bit = ~cond_eff;
        wr_en   = 1'b1;
      end
      BCI_F_RISE: begin
        new_bit = cond_eff & ~prev_cond;
        wr_en   = 1'b1;
      end
      BCI_F_FALL: begin
        new_bit = ~cond_eff & prev_cond;
        wr_en   = 1'b1;
      end
      BCI_F_LATCH: begin
        wr_en = 1'b1;
        // raw lines gated; reset wins over set, bit holds when both are off
        if (rst_eff) begin
          new_bit = 1'b0;
        end else if (cond_eff) begin
          new_bit = 1'b1;
        end else begin
          new_bit = cur_bit;
        end
      end
      default: begin
        new_bit = cur_bit;
        wr_en   = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // step qualifiers shared by the groups below
  // scan end wins over a step in the same cycle
  always_comb begin
    end_take  = (state_reg == BCI_S_RUN) && I_SCAN_END;
    step_take = (state_reg == BCI_S_RUN) && !I_SCAN_END && I_EXEC;
    bit_instr = (I_FUNC == BCI_F_OUT) || (I_FUNC == BCI_F_OUT_NOT) ||
                (I_FUNC == BCI_F_RISE) || (I_FUNC == BCI_F_FALL) ||
                (I_FUNC == BCI_F_LATCH);
  end

  // ==========================================================
  // read port next value
  // sees writes of earlier cycles only, never the one in flight
  always_comb begin
    case (I_RD_AREA)
      BCI_A_INT: rd_next = int_reg[I_RD_ADDR];
      BCI_A_RET: rd_next = ret_reg[I_RD_ADDR];
      BCI_A_AUX: rd_next = aux_reg[I_RD_ADDR];
      default:   rd_next = `BCI_BIT_RST;
    endcase
  end

  // ==========================================================
  // scan control next values
  always_comb begin
    state_next  = state_reg;
    pc_next     = pc_reg;
    closed_next = closed_reg;
    ext_next    = ext_reg;
    done_next   = 1'b0;
    err_next    = err_reg;
    case (state_reg)
      BCI_S_IDLE: begin
        if (I_SCAN_START) begin
          state_next  = BCI_S_RUN;
          pc_next     = '0;
          closed_next = 1'b0;
          err_next    = 1'b0;
        end
      end
      BCI_S_RUN: begin
        if (end_take) begin
          ext_next    = int_reg[OUT_BITS-1:0];
          done_next   = 1'b1;
          closed_next = 1'b0;
          state_next  = BCI_S_IDLE;
        end else if (step_take) begin
          // one instruction per step, in order
          pc_next = pc_reg + PW'(`BCI_PC_STEP);
          // history is per step, so running off the end is flagged
          if (pc_reg == PW'(PROG_LEN - 1)) begin
            err_next = 1'b1;
          end
          case (I_FUNC)
            BCI_F_SECTION: begin
              // nested sections: any closed one wins
              closed_next = closed_reg | ~I_COND;
            end
            BCI_F_SECT_CLR: begin
              closed_next = 1'b0;
            end
            BCI_F_OUT, BCI_F_OUT_NOT, BCI_F_RISE, BCI_F_FALL,
            BCI_F_LATCH: begin
              if (!valid_area) begin
                err_next = 1'b1;
              end
            end
            default: begin
              err_next = 1'b1;
            end
          endcase
        end
      end
      default: begin
        state_next = BCI_S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // bit store next values
  // a closed section still writes, with the gated condition
  always_comb begin
    int_next  = int_reg;
    ret_next  = ret_reg;
    aux_next  = aux_reg;
    hist_next = hist_reg;
    if (step_take && bit_instr) begin
      // history keeps the gated condition seen
      hist_next[pc_reg] = cond_eff;
      // any bit area takes the write
      if (wr_en && I_AREA == BCI_A_INT) begin
        int_next[I_ADDR] = new_bit;
      end
      if (wr_en && I_AREA == BCI_A_RET) begin
        ret_next[I_ADDR] = new_bit;
      end
      if (wr_en && I_AREA == BCI_A_AUX) begin
        aux_next[I_ADDR] = new_bit;
      end
    end
  end

  // ==========================================================
  // scan control registers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg  <= BCI_S_IDLE;
      pc_reg     <= '0;
      closed_reg <= 1'b0;
      ext_reg    <= '0;
      done_reg   <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      pc_reg     <= pc_next;
      closed_reg <= closed_next;
      ext_reg    <= ext_next;
      done_reg   <= done_next;
      err_reg    <= err_next;
    end
  end

  // ==========================================================
  // bit store registers; every area clears at power-on
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      int_reg  <= '0;
      ret_reg  <= '0;
      aux_reg  <= '0;
      hist_reg <= '0;
    end else begin
      int_reg  <= int_next;
      ret_reg  <= ret_next;
      aux_reg  <= aux_next;
      hist_reg <= hist_next;
    end
  end

  // ==========================================================
  // read port register
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rd_reg <= `BCI_BIT_RST;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign O_RD_BIT         = rd_reg;
  assign O_EXT_OUT        = ext_reg;
  assign O_PC             = pc_reg;
  assign O_SECTION_CLOSED = closed_reg;
  assign O_RUN            = state_reg;
  assign O_SCAN_DONE      = done_reg;
  assign O_ERR            = err_reg;

endmodule : bci_unit

// *** test/bci_unit_sva.sv ***
`timescale 1ns/10ps
// ==========================================================
// port checker for the bit control unit
module bci_unit_chk #(
  parameter int AREA_BITS = 256,
  parameter int PROG_LEN  = 256,
  parameter int OUT_BITS  = 16,
  parameter int AW        = $clog2(AREA_BITS),
  parameter int PW        = $clog2(PROG_LEN)
) (
  // clock, reset, framing
  input wire logic                  I_CLK,
  input wire logic                  I_RST,
  input wire logic                  I_SCAN_START,
  input wire logic                  I_SCAN_END,
  // instruction and read port
  input wire logic                  I_EXEC,
  input wire bci_pkg::bci_func_type I_FUNC,
  input wire bci_pkg::bci_area_type I_AREA,
  input wire logic [AW-1:0]         I_ADDR,
  input wire logic                  I_COND,
  input wire logic                  I_COND_RESET,
  input wire bci_pkg::bci_area_type I_RD_AREA,
  input wire logic [AW-1:0]         I_RD_ADDR,
  // unit outputs
  input wire logic                  O_RD_BIT,
  input wire logic [OUT_BITS-1:0]   O_EXT_OUT,
  input wire logic [PW-1:0]         O_PC,
  input wire logic                  O_SECTION_CLOSED,
  input wire logic                  O_RUN,
  input wire logic                  O_SCAN_DONE,
  input wire logic                  O_ERR
);
  import bci_pkg::*;
  logic take;
  logic hit;
  // taken step whose operand is also the read address
  assign take = O_RUN && I_EXEC && !I_SCAN_END;
  assign hit  = take && I_AREA != BCI_A_BAD && I_RD_AREA == I_AREA && I_RD_ADDR == I_ADDR;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // read address held so the readback shows this write
  sequence wr_s(e);
    hit && !O_SECTION_CLOSED && e ##1 $stable(I_RD_AREA) && $stable(I_RD_ADDR);
  endsequence
  // ==========================================================
  // assertions
  a_run_rise: assert property (!O_RUN && I_SCAN_START |=> O_RUN)
    else $error("scan did not start");
  a_scan_end: assert property (O_RUN && I_SCAN_END |=>
    !O_RUN && O_SCAN_DONE ##1 !O_SCAN_DONE) else $error("scan end framing wrong");
  a_pc_step: assert property (take |=> O_PC == $past(O_PC) + 1'b1)
    else $error("step count did not advance");
  a_bad_area: assert property (take && I_AREA == BCI_A_BAD |=> O_ERR)
    else $error("bad area not flagged");
  a_latch_set: assert property (wr_s(I_FUNC == BCI_F_LATCH && I_COND && !I_COND_RESET)
    |=> O_RD_BIT) else $error("latch set lost");
  a_latch_reset: assert property (wr_s(I_FUNC == BCI_F_LATCH && I_COND_RESET)
    |=> !O_RD_BIT) else $error("latch reset lost");
  a_out_store: assert property (wr_s(I_FUNC == BCI_F_OUT)
    |=> O_RD_BIT == $past(I_COND, 2)) else $error("output bit not stored");
  a_pins_hold: assert property ($changed(O_EXT_OUT) |-> O_SCAN_DONE)
    else $error("pins moved outside scan end");
  a_sect_close: assert property (take && I_FUNC == BCI_F_SECTION && !I_COND
    |=> O_SECTION_CLOSED) else $error("section did not close");
  a_sect_open: assert property (take && I_FUNC == BCI_F_SECT_CLR
    |=> !O_SECTION_CLOSED) else $error("section did not reopen");
  c_done: cover property (O_SCAN_DONE);
  c_rise: cover property (take && I_FUNC == BCI_F_RISE && I_COND);
  c_closed: cover property (take && O_SECTION_CLOSED);
  c_out_not: cover property (take && I_FUNC == BCI_F_OUT_NOT && I_COND);
endmodule : bci_unit_chk

// *** test/bci_prog_rom.sv ***
`timescale 1ns/10ps
// ==========================================================
// ladder program memory, addressed by the step count
module bci_prog_rom (
  // step and injected fault
  input  wire logic [7:0]       i_step,
  input  wire logic             i_bad,
  // instruction word
  output bci_pkg::bci_func_type o_func,
  output bci_pkg::bci_area_type o_area,
  output logic [7:0]            o_addr
);
  import bci_pkg::*;
  logic [17:0] w;
  // condition lines arrive with the word
  // work bits sit above the pin range
  always_comb begin
    case (i_step)
      8'h00: w = {BCI_F_RISE, BCI_A_INT, 8'h20};
      8'h01: w = {BCI_F_FALL, BCI_A_INT, 8'h21};
      8'h02: w = {BCI_F_LATCH, BCI_A_RET, 8'h03};
      8'h03: w = {BCI_F_SECTION, BCI_A_INT, 8'h00};
      8'h04: w = {BCI_F_LATCH, BCI_A_RET, 8'h03};
      8'h05: w = {BCI_F_OUT, BCI_A_AUX, 8'h07};
      8'h06: w = {BCI_F_SECT_CLR, BCI_A_INT, 8'h00};
      // inverted output drives pin bit 1
      default: w = {BCI_F_OUT_NOT, BCI_A_INT, 8'h01};
    endcase
  end
  // bad area only when a scenario asks for it
  assign o_func = bci_func_type'(w[17:10]);
  assign o_area = (i_bad && i_step == 8'h07) ? BCI_A_BAD : bci_area_type'(w[9:8]);
  assign o_addr = w[7:0];
endmodule : bci_prog_rom

// *** test/bci_unit_tb.sv ***
`timescale 1ns/10ps
// ==========================================================
// scan-level bench for the bit control unit
module bci_unit_tb;
  import bci_pkg::*;
  logic         clk = 1'b0, rst = 1'b1, start = 1'b0, send = 1'b0;
  logic         exec = 1'b0, cnd = 1'b0, crst = 1'b0, bad = 1'b0;
  bci_area_type rd_area = BCI_A_INT, area;
  logic [7:0]   rd_addr = 8'h00, addr, pc;
  bci_func_type func;
  logic [15:0]  ext;
  logic         rd_bit, closed, run, done, err;
  int           error_cnt = 0, total_checks = 0;
  // 40 MHz
  always #12.5 clk = ~clk;
  bci_unit i_dut (
    .I_CLK(clk), .I_RST(rst), .I_SCAN_START(start), .I_SCAN_END(send),
    .I_EXEC(exec), .I_FUNC(func), .I_AREA(area), .I_ADDR(addr),
    .I_COND(cnd), .I_COND_RESET(crst), .I_RD_AREA(rd_area), .I_RD_ADDR(rd_addr),
    .O_RD_BIT(rd_bit), .O_EXT_OUT(ext), .O_PC(pc), .O_SECTION_CLOSED(closed),
    .O_RUN(run), .O_SCAN_DONE(done), .O_ERR(err));
  bci_prog_rom i_prog (.i_step(pc), .i_bad(bad), .o_func(func), .o_area(area), .o_addr(addr));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one scan of eight steps; c and r give each step's lines
  task automatic scan(input logic [7:0] c, input logic [7:0] r, input logic b);
    @(posedge clk);
    start <= 1'b1;
    bad <= b;
    @(posedge clk);
    start <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      exec <= 1'b1;
      cnd <= c[k];
      crst <= r[k];
      @(posedge clk);
    end
    exec <= 1'b0;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    #1 check({15'h0, done}, 16'h0001);
  endtask : scan
  // read port lags by a store and a register stage
  task automatic rd_chk(input bci_area_type a, input logic [7:0] d, input logic e);
    @(posedge clk);
    rd_area <= a;
    rd_addr <= d;
    repeat (3) @(posedge clk);
    #1 check({15'h0, rd_bit}, {15'h0, e});
  endtask : rd_chk
  task automatic t_edges;
    scan(8'h0a, 8'h00, 1'b0);
    rd_chk(BCI_A_INT, 8'h20, 1'b0);
    rd_chk(BCI_A_INT, 8'h21, 1'b0);
    scan(8'h09, 8'h00, 1'b0);
    rd_chk(BCI_A_INT, 8'h20, 1'b1);
    rd_chk(BCI_A_INT, 8'h21, 1'b1);
    scan(8'h09, 8'h00, 1'b0);
    rd_chk(BCI_A_INT, 8'h20, 1'b0);
    rd_chk(BCI_A_INT, 8'h21, 1'b0);
  endtask : t_edges
  task automatic t_latch;
    scan(8'h0d, 8'h00, 1'b0);
    rd_chk(BCI_A_RET, 8'h03, 1'b1);
    scan(8'h09, 8'h00, 1'b0);
    rd_chk(BCI_A_RET, 8'h03, 1'b1);
    scan(8'h0d, 8'h04, 1'b0);
    rd_chk(BCI_A_RET, 8'h03, 1'b0);
  endtask : t_latch
  task automatic t_section;
    scan(8'h2d, 8'h00, 1'b0);
    // last step inverts an idle line, so pin bit 1 is lit
    check(ext, 16'h0002);
    rd_chk(BCI_A_AUX, 8'h07, 1'b1);
    scan(8'h31, 8'h10, 1'b0);
    rd_chk(BCI_A_RET, 8'h03, 1'b1);
    rd_chk(BCI_A_AUX, 8'h07, 1'b0);
  endtask : t_section
  task automatic t_pins;
    // a lit line on the inverting last step clears pin bit 1
    scan(8'h89, 8'h00, 1'b0);
    check(ext, 16'h0000);
    check({15'h0, err}, 16'h0000);
    // bad area on the last step: no write, pin bit 1 stays clear
    scan(8'h09, 8'h00, 1'b1);
    check(ext, 16'h0000);
    check({15'h0, err}, 16'h0001);
  endtask : t_pins
  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check(ext, 16'h0000);
    t_edges();
    t_latch();
    t_section();
    t_pins();
    results();
  end
endmodule : bci_unit_tb
bind bci_unit bci_unit_chk #(.AREA_BITS(AREA_BITS), .PROG_LEN(PROG_LEN), .OUT_BITS(OUT_BITS))
  i_chk (.I_CLK, .I_RST, .I_SCAN_START, .I_SCAN_END, .I_EXEC, .I_FUNC, .I_AREA, .I_ADDR,
  .I_COND, .I_COND_RESET, .I_RD_AREA, .I_RD_ADDR, .O_RD_BIT, .O_EXT_OUT, .O_PC,
  .O_SECTION_CLOSED, .O_RUN, .O_SCAN_DONE, .O_ERR);
